// ===== sdg_top.v
// servo control io mapping, limits, brake stop and deviation guard
//
// How it works
// - speed mode output codes 0, 1, 2
// - torque mode ignores the code, uses the code 1 routing
// - latched settings change only at power-up
// - five input polarity bits, set means open
// - four output polarity bits, default two
// - output five has fixed polarity
// - control inputs filtered, 0 to 127 ms
// - speed-limit input clamps speed to limit
// - no speed limit in torque mode
// - current-limit input applies directional ceilings
// - brake setting chooses braked stop or coast
// - direction setting swaps forward and reverse
// - deviation is command minus feedback count
// - over-deviation raises alarm, removes servo power
// - mode 0 position, 1 speed, 2 torque
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "sdg_map.vh"
module sdg_top #(
   parameter TICKS_PER_MS = `SDG_MS_NS / `SDG_CLK_NS
) (
   input wire sys_clk,
   input wire rstn,
   input wire [7:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdata,
   output reg irq,
   input wire [4:0] ctlIn,
   input wire cmdFwdPulse,
   input wire cmdRevPulse,
   input wire fbFwdPulse,
   input wire fbRevPulse,
   input wire phaseZ,
   input wire powerCycle,
   input wire [15:0] speedFb,
   input wire [15:0] speedReq,
   input wire [9:0] curReqPct,
   input wire curReqRev,
   output reg [4:0] ctlOut,
   output reg servoPower,
   output reg brakeStop,
   output reg [15:0] speedCmd,
   output reg [9:0] curCmdPct,
   output reg cmdFwdOut,
   output reg cmdRevOut
);
   localparam ST_OFF = 2'd0, ST_ON = 2'd1, ST_BRAKE = 2'd2;
   function [3:0] mapOuts;
      input [2:0] mode;
      input [4:0] code;
      input attain, alarm, ready, spdLim, curLim;
      begin
         if (mode == `SDG_MODE_TRQ) begin
            mapOuts = {curLim, ready, alarm, attain};
         end else begin
            case (code)
               5'h01: mapOuts = {curLim, ready, alarm, attain};
               5'h02: mapOuts = {curLim, spdLim, alarm, attain};
               // reserved codes fall back to the default routing
               default: mapOuts = {spdLim, ready, alarm, attain};
            endcase
         end
      end
   endfunction

   // shadow settings written by software
   reg [2:0] modeSh_reg;
   reg [4:0] outSelSh_reg, inPolSh_reg;
   reg [3:0] outPolSh_reg;
   reg [9:0] fwdCurSh_reg, revCurSh_reg;
   reg dirSh_reg;
   // immediately effective settings
   reg [6:0] filt_reg;
   reg [15:0] spdLim_reg, devMax_reg, attain_reg, inPos_reg;
   reg brake_reg;
   reg [3:0] status_reg, mask_reg;
   // values latched at power-up
   reg [2:0] mode_reg;
   reg [4:0] outSel_reg, inPol_reg;
   reg [3:0] outPol_reg;
   reg [9:0] fwdCur_reg, revCur_reg;
   reg dir_reg, load_reg;
   reg [10:0] sync1_reg, sync2_reg, sync3_reg;
   reg [24:0] pre_reg;
   reg [1:0] state_reg, state_next;
   reg msTick_reg, alarm_reg, spdLimAct_reg, curLimAct_reg;
   wire [4:0] inActive, inFilt;
   wire [10:0] rise;
   wire [23:0] devCount, devAbs;
   wire [3:0] funcOut;
   wire [9:0] curCeil;
   wire svOnReq, alarmClr, devClr, spdLimReq, curLimReq;
   wire cmdUp, cmdDn, overDev, spdClamp, curClamp, statusRd;

   // the third stage is only for edge detection of pulse and power-cycle inputs
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         // control pins rest high: zeros would read as requests at reset
         sync1_reg <= 11'h01f;
         sync2_reg <= 11'h01f;
         sync3_reg <= 11'h01f;
      end else begin
         sync1_reg <= {powerCycle, phaseZ, fbRevPulse, fbFwdPulse,
            cmdRevPulse, cmdFwdPulse, ctlIn};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   assign rise = sync2_reg & ~sync3_reg;
   // a clear polarity bit means the contact is normally closed
   assign inActive = sync2_reg[4:0] ^ ~inPol_reg;
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pre_reg <= 25'h0000000;
         msTick_reg <= 1'b0;
      end else if (pre_reg >= TICKS_PER_MS - 1) begin
         pre_reg <= 25'h0000000;
         msTick_reg <= 1'b1;
      end else begin
         pre_reg <= pre_reg + 25'h0000001;
         msTick_reg <= 1'b0;
      end
   end

   // command pulses bypass the filter, only control inputs go through
   sdg_in_filter u_filter (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .msTick(msTick_reg),
      .tcMs(filt_reg),
      .rawIn(inActive),
      .filtOut(inFilt)
   );

   assign svOnReq = inFilt[0];
   assign alarmClr = inFilt[1];
   assign devClr = inFilt[2];
   assign spdLimReq = inFilt[3];
   assign curLimReq = inFilt[4];

   assign cmdUp = dir_reg ? rise[6] : rise[5];
   assign cmdDn = dir_reg ? rise[5] : rise[6];

   sdg_dev_counter u_dev (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .cmdUp(cmdUp),
      .cmdDn(cmdDn),
      .fbUp(rise[7]),
      .fbDn(rise[8]),
      .clear(devClr),
      .devCount(devCount)
   );
   assign devAbs = devCount[23] ? 24'h000000 - devCount : devCount;
   assign overDev = devAbs > {8'h00, devMax_reg};
   // power-up latch: at reset release and at every power cycle
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         load_reg <= 1'b1;
         mode_reg <= `SDG_RST_MODE;
         outSel_reg <= `SDG_RST_OUTSEL;
         inPol_reg <= `SDG_RST_INPOL;
         outPol_reg <= `SDG_RST_OUTPOL;
         fwdCur_reg <= `SDG_RST_CUR;
         revCur_reg <= `SDG_RST_CUR;
         dir_reg <= 1'b0;
      end else begin
         load_reg <= rise[10];
         if (load_reg) begin
            mode_reg <= modeSh_reg;
            outSel_reg <= outSelSh_reg;
            inPol_reg <= inPolSh_reg;
            outPol_reg <= outPolSh_reg;
            fwdCur_reg <= fwdCurSh_reg;
            revCur_reg <= revCurSh_reg;
            dir_reg <= dirSh_reg;
         end
      end
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         alarm_reg <= 1'b0;
      end else if (overDev) begin
         alarm_reg <= 1'b1;
      end else if (alarmClr) begin
         alarm_reg <= 1'b0;
      end
   end

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (svOnReq && !alarm_reg)
               state_next = ST_ON;
         end
         ST_ON: begin
            if (alarm_reg)
               state_next = ST_OFF;
            else if (!svOnReq)
               state_next = brake_reg ? ST_BRAKE : ST_OFF;
         end
         ST_BRAKE: begin
            if (alarm_reg || speedFb == 16'h0000)
               state_next = ST_OFF;
         end
         default: state_next = ST_OFF;
      endcase
   end
   // limits are only honoured while the request input is active
   assign spdClamp = spdLimReq && mode_reg != `SDG_MODE_TRQ &&
      speedReq > spdLim_reg;
   assign curCeil = curReqRev ? revCur_reg : fwdCur_reg;
   assign curClamp = curLimReq && curReqPct > curCeil;

   assign funcOut = mapOuts(mode_reg, outSel_reg,
      mode_reg == `SDG_MODE_POS ? devAbs <= {8'h00, inPos_reg}
                                : speedFb > attain_reg,
      alarm_reg, !alarm_reg && state_reg == ST_ON,
      spdClamp, curClamp);

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_OFF;
         servoPower <= 1'b0;
         brakeStop <= 1'b0;
         speedCmd <= 16'h0000;
         curCmdPct <= 10'h000;
         cmdFwdOut <= 1'b0;
         cmdRevOut <= 1'b0;
         ctlOut <= 5'h00;
         spdLimAct_reg <= 1'b0;
         curLimAct_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         servoPower <= state_next != ST_OFF;
         brakeStop <= state_next == ST_BRAKE;
         speedCmd <= spdClamp ? spdLim_reg : speedReq;
         curCmdPct <= curClamp ? curCeil : curReqPct;
         cmdFwdOut <= cmdUp;
         cmdRevOut <= cmdDn;
         spdLimAct_reg <= spdClamp;
         curLimAct_reg <= curClamp;
         ctlOut[3:0] <= funcOut ^ ~outPol_reg;
         ctlOut[4] <= sync2_reg[9];
      end
   end

   assign statusRd = regRd && regAddr == `SDG_A_STATUS;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         modeSh_reg <= `SDG_RST_MODE;
         outSelSh_reg <= `SDG_RST_OUTSEL;
         inPolSh_reg <= `SDG_RST_INPOL;
         outPolSh_reg <= `SDG_RST_OUTPOL;
         fwdCurSh_reg <= `SDG_RST_CUR;
         revCurSh_reg <= `SDG_RST_CUR;
         dirSh_reg <= 1'b0;
         filt_reg <= `SDG_RST_FILT;
         spdLim_reg <= `SDG_RST_SPDLIM;
         brake_reg <= 1'b0;
         devMax_reg <= `SDG_RST_DEVMAX;
         attain_reg <= `SDG_RST_ATTAIN;
         inPos_reg <= `SDG_RST_INPOS;
         mask_reg <= 4'h0;
      end else if (regWr) begin
         case (regAddr)
            `SDG_A_MODE: modeSh_reg <= regWdata[2:0];
            `SDG_A_OUTSEL: outSelSh_reg <= regWdata[4:0];
            `SDG_A_INPOL: inPolSh_reg <= regWdata[4:0];
            `SDG_A_OUTPOL: outPolSh_reg <= regWdata[3:0];
            `SDG_A_FILT: filt_reg <= regWdata[6:0];
            `SDG_A_SPDLIM: spdLim_reg <= regWdata[15:0];
            `SDG_A_FWDCUR: fwdCurSh_reg <= regWdata[9:0];
            `SDG_A_REVCUR: revCurSh_reg <= regWdata[9:0];
            `SDG_A_CTRL: begin
               brake_reg <= regWdata[`SDG_CTRL_BRAKE];
               dirSh_reg <= regWdata[`SDG_CTRL_DIR];
            end
            `SDG_A_DEVMAX: devMax_reg <= regWdata[15:0];
            `SDG_A_MASK: mask_reg <= regWdata[3:0];
            `SDG_A_ATTAIN: attain_reg <= regWdata[15:0];
            `SDG_A_INPOS: inPos_reg <= regWdata[15:0];
            default: mask_reg <= mask_reg;
         endcase
      end
   end

   // event sets win over the clear done by reading the status register
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         status_reg <= 4'h0;
         irq <= 1'b0;
      end else begin
         status_reg <= (statusRd ? 4'h0 : status_reg) |
            {state_reg != ST_OFF && state_next == ST_OFF,
             curClamp && !curLimAct_reg,
             spdClamp && !spdLimAct_reg,
             overDev && !alarm_reg};
         irq <= |(status_reg & mask_reg & ~{4{statusRd}});
      end
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 32'h00000000;
      end else if (regRd) begin
         case (regAddr)
            `SDG_A_MODE: regRdata <= {29'h0, modeSh_reg};
            `SDG_A_OUTSEL: regRdata <= {27'h0, outSelSh_reg};
            `SDG_A_INPOL: regRdata <= {27'h0, inPolSh_reg};
            `SDG_A_OUTPOL: regRdata <= {28'h0, outPolSh_reg};
            `SDG_A_FILT: regRdata <= {25'h0, filt_reg};
            `SDG_A_SPDLIM: regRdata <= {16'h0, spdLim_reg};
            `SDG_A_FWDCUR: regRdata <= {22'h0, fwdCurSh_reg};
            `SDG_A_REVCUR: regRdata <= {22'h0, revCurSh_reg};
            `SDG_A_CTRL: regRdata <= {30'h0, dirSh_reg, brake_reg};
            `SDG_A_DEVMAX: regRdata <= {16'h0, devMax_reg};
            `SDG_A_STATUS: regRdata <= {28'h0, status_reg};
            `SDG_A_MASK: regRdata <= {28'h0, mask_reg};
            `SDG_A_STATE: regRdata <= {18'h0, inFilt, state_reg,
               alarm_reg, dir_reg, mode_reg, curLimAct_reg, spdLimAct_reg};
            `SDG_A_DEV: regRdata <= {{8{devCount[23]}}, devCount};
            `SDG_A_ATTAIN: regRdata <= {16'h0, attain_reg};
            `SDG_A_INPOS: regRdata <= {16'h0, inPos_reg};
            default: regRdata <= 32'h00000000;
         endcase
      end else begin
         regRdata <= 32'h00000000;
      end
   end
endmodule

// ===== sdg_map.vh
// register map, field layout, reset values and timing for the servo io guard
`ifndef SDG_MAP_VH
`define SDG_MAP_VH

`define SDG_A_MODE 8'h00
`define SDG_A_OUTSEL 8'h04
`define SDG_A_INPOL 8'h08
`define SDG_A_OUTPOL 8'h0c
`define SDG_A_FILT 8'h10
`define SDG_A_SPDLIM 8'h14
`define SDG_A_FWDCUR 8'h18
`define SDG_A_REVCUR 8'h1c
`define SDG_A_CTRL 8'h20
`define SDG_A_DEVMAX 8'h24
`define SDG_A_STATUS 8'h28
`define SDG_A_MASK 8'h2c
`define SDG_A_STATE 8'h30
`define SDG_A_DEV 8'h34
`define SDG_A_ATTAIN 8'h38
`define SDG_A_INPOS 8'h3c

`define SDG_CTRL_BRAKE 0
`define SDG_CTRL_DIR 1

`define SDG_ST_ALARM 0
`define SDG_ST_SPDLIM 1
`define SDG_ST_CURLIM 2
`define SDG_ST_SVOFF 3

`define SDG_MODE_POS 3'h0
`define SDG_MODE_SPD 3'h1
`define SDG_MODE_TRQ 3'h2

`define SDG_RST_MODE 3'h0
`define SDG_RST_OUTSEL 5'h00
`define SDG_RST_INPOL 5'h00
`define SDG_RST_OUTPOL 4'h2
`define SDG_RST_FILT 7'h00
`define SDG_RST_SPDLIM 16'h0bb8
`define SDG_RST_CUR 10'h12c
`define SDG_RST_DEVMAX 16'h7530
`define SDG_RST_ATTAIN 16'h0064
`define SDG_RST_INPOS 16'h000a

`define SDG_CLK_NS 40
`define SDG_MS_NS 1000000

`endif

// ===== sdg_in_filter.v
// per-input low-pass filter with a time constant in milliseconds
`timescale 1ns/1ns
module sdg_in_filter (
   input wire sys_clk,
   input wire rstn,
   input wire msTick,
   input wire [6:0] tcMs,
   input wire [4:0] rawIn,
   output wire [4:0] filtOut
);
   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1) begin : g_bit
         reg [6:0] cnt_reg;
         reg out_reg;
         assign filtOut[i] = out_reg;
         always @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               cnt_reg <= 7'h00;
               out_reg <= 1'b0;
            end else if (rawIn[i] == out_reg) begin
               cnt_reg <= 7'h00;
            end else if (tcMs == 7'h00) begin
               out_reg <= rawIn[i];
            end else if (msTick) begin
               // level must hold through tcMs millisecond ticks before it passes
               if (cnt_reg + 7'h01 >= tcMs) begin
                  out_reg <= rawIn[i];
                  cnt_reg <= 7'h00;
               end else begin
                  cnt_reg <= cnt_reg + 7'h01;
               end
            end
         end
      end
   endgenerate
endmodule

// ===== sdg_dev_counter.v
// position deviation counter: command count minus feedback count
`timescale 1ns/1ns
module sdg_dev_counter (
   input wire sys_clk,
   input wire rstn,
   input wire cmdUp,
   input wire cmdDn,
   input wire fbUp,
   input wire fbDn,
   input wire clear,
   output reg [23:0] devCount
);
   reg [23:0] delta;
   always @* begin
      delta = {{22{1'b0}}, cmdUp, 1'b0} + {{22{1'b0}}, fbDn, 1'b0};
      delta = delta - {{22{1'b0}}, cmdDn, 1'b0} - {{22{1'b0}}, fbUp, 1'b0};
      delta = {delta[23], delta[23:1]};
   end
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         devCount <= 24'h000000;
      end else if (clear) begin
         devCount <= 24'h000000;
      end else begin
         devCount <= devCount + delta;
      end
   end
endmodule

// ===== sdg_top_checker.sv
// port-level assertions for the servo io guard
`timescale 1ns/1ns
module sdg_top_checker #(
   parameter TICKS_PER_MS = 25000
) (
   input wire sys_clk,
   input wire rstn,
   input wire regRd,
   input wire [31:0] regRdata,
   input wire phaseZ,
   input wire cmdFwdPulse,
   input wire cmdRevPulse,
   input wire cmdFwdOut,
   input wire cmdRevOut,
   input wire [15:0] speedFb,
   input wire [15:0] speedReq,
   input wire [9:0] curReqPct,
   input wire [15:0] speedCmd,
   input wire [9:0] curCmdPct,
   input wire [4:0] ctlOut,
   input wire servoPower,
   input wire brakeStop
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_cmd_rise;
      $rose(cmdFwdPulse) || $rose(cmdRevPulse);
   endsequence
   sequence s_cmd_out;
      cmdFwdOut || cmdRevOut;
   endsequence
   sequence s_brake_done;
      brakeStop && speedFb == 16'h0000;
   endsequence
   property p_cmd_follow;
      s_cmd_rise |-> ##[1:5] s_cmd_out;
   endproperty
   a_cmd_follow: assert property (p_cmd_follow)
      else $error("command pulse not passed on");
   property p_cmd_single;
      s_cmd_out |=> !cmdFwdOut && !cmdRevOut;
   endproperty
   a_cmd_single: assert property (p_cmd_single)
      else $error("command output longer than one cycle");
   property p_cmd_excl;
      !(cmdFwdOut && cmdRevOut);
   endproperty
   a_cmd_excl: assert property (p_cmd_excl)
      else $error("both command outputs at once");
   property p_z_rise;
      $rose(phaseZ) |-> ##[1:5] ctlOut[4];
   endproperty
   a_z_rise: assert property (p_z_rise)
      else $error("phase pulse output did not follow");
   property p_z_fall;
      $fell(phaseZ) |-> ##[1:5] !ctlOut[4];
   endproperty
   a_z_fall: assert property (p_z_fall)
      else $error("phase pulse output inverted or stuck");
   property p_rd_idle;
      !$past(regRd) |-> regRdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read cycle");
   property p_brake_hold;
      $rose(brakeStop) |-> servoPower;
   endproperty
   a_brake_hold: assert property (p_brake_hold)
      else $error("braking without servo power");
   property p_brake_end;
      s_brake_done |-> ##[1:3] (!brakeStop && !servoPower);
   endproperty
   a_brake_end: assert property (p_brake_end)
      else $error("servo not off after braked stop");
   // a settled request only: the clamp is registered one cycle
   property p_spd_clamp;
      $stable(speedReq) && speedReq == $past(speedReq, 2)
         |-> speedCmd <= speedReq;
   endproperty
   a_spd_clamp: assert property (p_spd_clamp)
      else $error("speed command above request");
   property p_cur_clamp;
      $stable(curReqPct) && curReqPct == $past(curReqPct, 2)
         |-> curCmdPct <= curReqPct;
   endproperty
   a_cur_clamp: assert property (p_cur_clamp)
      else $error("current command above request");
endmodule

bind sdg_top sdg_top_checker #(.TICKS_PER_MS(TICKS_PER_MS)) i_chk (
   .sys_clk(sys_clk), .rstn(rstn), .regRd(regRd), .regRdata(regRdata),
   .phaseZ(phaseZ), .cmdFwdPulse(cmdFwdPulse), .cmdRevPulse(cmdRevPulse),
   .cmdFwdOut(cmdFwdOut), .cmdRevOut(cmdRevOut), .speedFb(speedFb),
   .speedReq(speedReq), .curReqPct(curReqPct), .speedCmd(speedCmd),
   .curCmdPct(curCmdPct), .ctlOut(ctlOut), .servoPower(servoPower),
   .brakeStop(brakeStop));

// ===== sdg_host_model.sv
// host controller model: discrete input pins and pulse lines
`timescale 1ns/1ns
module sdg_host_model (
   input wire sys_clk,
   output logic [4:0] ctlIn,
   output logic [3:0] pulseOut,
   output logic phaseZ
);
   // pins idle high: with closed-contact polarity nothing is requested
   initial begin
      ctlIn = 5'h1f;
      pulseOut = 4'h0;
      phaseZ = 1'b0;
   end
   task pins(input logic [4:0] v);
      @(posedge sys_clk);
      ctlIn <= v;
   endtask
   // a low cycle after every high one keeps the rises apart
   task pulse(input int sel, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         if (sel == 4)
            phaseZ <= 1'b1;
         else
            pulseOut[sel] <= 1'b1;
         @(posedge sys_clk);
         phaseZ <= 1'b0;
         pulseOut <= 4'h0;
      end
   endtask
endmodule

// ===== sdg_top_tb.sv
// self-checking bench for the servo io guard
`timescale 1ns/1ns
`include "sdg_map.vh"
module sdg_top_tb;
   logic sys_clk, rstn, regWr, regRd, powerCycle;
   logic curReqRev, phaseZ, irq, servoPower, brakeStop;
   logic cmdFwdOut, cmdRevOut;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata, rd;
   logic [15:0] speedFb, speedReq, speedCmd;
   logic [9:0] curReqPct, curCmdPct;
   logic [4:0] ctlIn, ctlOut;
   logic [3:0] pls;
   int error_cnt = 0, compares = 0;
   always #20 sys_clk = ~sys_clk;
   sdg_host_model i_host (.sys_clk(sys_clk), .ctlIn(ctlIn),
      .pulseOut(pls), .phaseZ(phaseZ));
   sdg_top #(.TICKS_PER_MS(4)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .irq(irq), .ctlIn(ctlIn),
      .cmdFwdPulse(pls[0]), .cmdRevPulse(pls[1]), .fbFwdPulse(pls[2]),
      .fbRevPulse(pls[3]), .phaseZ(phaseZ), .powerCycle(powerCycle),
      .speedFb(speedFb), .speedReq(speedReq), .curReqPct(curReqPct),
      .curReqRev(curReqRev), .ctlOut(ctlOut), .servoPower(servoPower),
      .brakeStop(brakeStop), .speedCmd(speedCmd), .curCmdPct(curCmdPct),
      .cmdFwdOut(cmdFwdOut), .cmdRevOut(cmdRevOut));
   task chk(input string n, input logic [31:0] got, input logic [31:0] e);
      compares++;
      if (got !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, got);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task rdreg(input logic [7:0] a);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 rd = regRdata;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
      rdreg(a);
      chk(n, rd, e);
   endtask
   // latched settings reload only on this edge, as at power-up
   task pcyc;
      @(posedge sys_clk);
      powerCycle <= 1'b1;
      repeat (3) @(posedge sys_clk);
      powerCycle <= 1'b0;
      cyc(6);
   endtask
   task t_defaults;
      rchk(`SDG_A_MODE, 32'h0, "mode");
      rchk(`SDG_A_OUTPOL, 32'h2, "outpol");
      rchk(`SDG_A_INPOL, 32'h0, "inpol");
      rchk(8'h40, 32'h0, "unmapped");
      chk("idle outputs", ctlOut[3:0], 4'hc);
      i_host.pulse(4, 2);
   endtask
   task t_inputs;
      i_host.pins(5'h15);
      cyc(8);
      rdreg(`SDG_A_STATE);
      chk("closed pol", rd[13:9], 5'h0a);
      wr(`SDG_A_INPOL, 32'h1f);
      rdreg(`SDG_A_STATE);
      chk("pol held", rd[13:9], 5'h0a);
      pcyc;
      rdreg(`SDG_A_STATE);
      chk("open pol", rd[13:9], 5'h15);
      wr(`SDG_A_FILT, 32'h2);
      i_host.pins(5'h17);
      cyc(2);
      rdreg(`SDG_A_STATE);
      chk("filter hold", rd[13:9], 5'h15);
      cyc(16);
      rdreg(`SDG_A_STATE);
      chk("filter pass", rd[13:9], 5'h17);
      wr(`SDG_A_FILT, 32'h0);
      wr(`SDG_A_INPOL, 32'h0);
      i_host.pins(5'h1f);
      pcyc;
   endtask
   task t_servo;
      // drop off events left by the earlier scenarios
      rdreg(`SDG_A_STATUS);
      wr(`SDG_A_MASK, 32'h8);
      wr(`SDG_A_CTRL, 32'h1);
      speedFb <= 16'd100;
      i_host.pins(5'h1e);
      cyc(8);
      chk("power on", servoPower, 1'b1);
      i_host.pins(5'h1f);
      cyc(8);
      chk("braking", {brakeStop, servoPower}, 2'b11);
      @(posedge sys_clk) speedFb <= 16'h0000;
      cyc(5);
      chk("stopped", {brakeStop, servoPower}, 2'b00);
      chk("irq off event", irq, 1'b1);
      rdreg(`SDG_A_STATUS);
      chk("status off", rd[3], 1'b1);
      cyc(1);
      chk("irq cleared", irq, 1'b0);
      wr(`SDG_A_CTRL, 32'h0);
      i_host.pins(5'h1e);
      cyc(8);
      @(posedge sys_clk) speedFb <= 16'd200;
      i_host.pins(5'h1f);
      cyc(6);
      chk("coast", {brakeStop, servoPower}, 2'b00);
   endtask
   task t_dev;
      wr(`SDG_A_MASK, 32'h1);
      i_host.pins(5'h1e);
      i_host.pulse(0, 5);
      i_host.pulse(2, 2);
      i_host.pulse(1, 1);
      cyc(6);
      rchk(`SDG_A_DEV, 32'h2, "deviation");
      wr(`SDG_A_DEVMAX, 32'h4);
      i_host.pulse(0, 3);
      cyc(6);
      chk("alarm off", {servoPower, ctlOut[1], irq}, 3'b011);
      rdreg(`SDG_A_STATUS);
      chk("status alarm", rd[0], 1'b1);
      i_host.pins(5'h1c);
      cyc(8);
      chk("alarm held", {servoPower, ctlOut[1]}, 2'b01);
      i_host.pins(5'h18);
      cyc(8);
      i_host.pins(5'h1e);
      cyc(8);
      chk("alarm gone", {servoPower, ctlOut[1]}, 2'b10);
      i_host.pulse(2, 1);
      cyc(6);
      rchk(`SDG_A_DEV, 32'hffffffff, "negative");
      wr(`SDG_A_DEVMAX, 32'h7530);
   endtask
   task t_limits;
      wr(`SDG_A_SPDLIM, 32'd500);
      speedReq <= 16'd800;
      curReqPct <= 10'd250;
      i_host.pins(5'h16);
      cyc(8);
      chk("speed clamp", speedCmd, 16'd500);
      chk("no cur clamp", curCmdPct, 10'd250);
      wr(`SDG_A_FWDCUR, 32'd200);
      i_host.pins(5'h06);
      cyc(8);
      chk("old ceiling", curCmdPct, 10'd250);
      pcyc;
      chk("fwd ceiling", curCmdPct, 10'd200);
      @(posedge sys_clk) curReqRev <= 1'b1;
      cyc(4);
      chk("rev ceiling", curCmdPct, 10'd250);
      @(posedge sys_clk) curReqRev <= 1'b0;
   endtask
   task t_modes;
      logic [3:0] outExp [3] = '{4'h9, 4'h1, 4'h5};
      i_host.pins(5'h17);
      wr(`SDG_A_OUTPOL, 32'hf);
      wr(`SDG_A_MODE, 32'h1);
      for (int c = 0; c < 3; c++) begin
         wr(`SDG_A_OUTSEL, c);
         pcyc;
         chk("speed map", ctlOut[3:0], outExp[c]);
      end
      wr(`SDG_A_CTRL, 32'h2);
      pcyc;
      rdreg(`SDG_A_STATE);
      chk("dir and mode", rd[5:2], 4'h9);
      i_host.pulse(0, 1);
      for (int i = 0; i < 6 && cmdFwdOut !== 1'b1 && cmdRevOut !== 1'b1; i++)
         cyc(1);
      chk("swapped", {cmdFwdOut, cmdRevOut}, 2'b01);
      wr(`SDG_A_MODE, 32'h2);
      wr(`SDG_A_OUTSEL, 32'h0);
      pcyc;
      chk("torque map", ctlOut[3:0], 4'h1);
      chk("no torque clamp", speedCmd, 16'd800);
   endtask
   task final_report;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      rstn <= 1'b0;
      regWr <= 1'b0;
      regRd <= 1'b0;
      powerCycle <= 1'b0;
      curReqRev <= 1'b0;
      regAddr <= 8'h00;
      regWdata <= 32'h00000000;
      speedFb <= 16'h0000;
      speedReq <= 16'h0000;
      curReqPct <= 10'h000;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      t_defaults;
      t_inputs;
      t_servo;
      t_dev;
      t_limits;
      t_modes;
      final_report;
   end
   // the whole sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      final_report;
   end
endmodule
